// ### core/band_pkg.sv
package band_pkg;

    // widths
    localparam int VAL_W = 16;
    localparam int WORD_W = 32;
    localparam int ADR_W = 8;
    localparam int PEER_NUM = 8;
    localparam int PEER_SEL_W = 3;
    localparam int IRQ_W = 3;
    localparam int DEC_W = 2;

    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] GAIN_OFS = 8'h04;
    localparam logic [7:0] OFFSET_OFS = 8'h08;
    localparam logic [7:0] UPPER_OFS = 8'h0c;
    localparam logic [7:0] LOWER_OFS = 8'h10;
    localparam logic [7:0] MSRC_OFS = 8'h14;
    localparam logic [7:0] STATE_OFS = 8'h18;
    localparam logic [7:0] REF_OFS = 8'h1c;
    localparam logic [7:0] LIVE_OFS = 8'h20;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h28;

    // field positions
    localparam int CTRL_PHYS_BIT = 0;
    localparam int CTRL_RETAIN_BIT = 1;
    localparam int CTRL_LEGACY_BIT = 2;
    localparam int CTRL_DEC_LSB = 4;
    localparam int MSRC_UP_SEL_LSB = 0;
    localparam int MSRC_UP_PEER_BIT = 3;
    localparam int MSRC_LO_SEL_LSB = 4;
    localparam int MSRC_LO_PEER_BIT = 7;
    localparam int STATE_OUT_BIT = 0;
    localparam int STATE_EN_BIT = 1;
    localparam int STATE_ARMED_BIT = 2;
    localparam int IRQ_EXIT_BIT = 0;
    localparam int IRQ_RETURN_BIT = 1;
    localparam int IRQ_CAPTURE_BIT = 2;

    // value limits; gain is in hundredths
    localparam logic signed [31:0] GAIN_MIN = -32'sd1000;
    localparam logic signed [31:0] GAIN_MAX = 32'sd1000;
    localparam logic signed [31:0] LEGACY_GAIN_MIN = 32'sd0;
    localparam logic signed [31:0] OFFSET_MIN = -32'sd10000;
    localparam logic signed [31:0] OFFSET_MAX = 32'sd10000;
    localparam logic signed [31:0] MARGIN_MIN = 32'sd0;
    localparam logic signed [31:0] MARGIN_MAX = 32'sd20000;
    localparam logic signed [31:0] PHYS_MIN = 32'sd0;
    localparam logic signed [31:0] PHYS_MAX = 32'sd1000;
    localparam logic signed [31:0] SCALE_HUNDRED = 32'sd100;

    // reset values
    localparam logic signed [15:0] GAIN_RST = 16'sh0064;
    localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
    localparam logic [15:0] MARGIN_RST = 16'h0000;
    localparam logic [7:0] MSRC_RST = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

endpackage

// ### core/band_if.sv
`timescale 1ns/10ps
interface band_if;
    logic signed [15:0] raw;
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic signed [31:0] scaled;
    logic signed [31:0] ref_val;
    logic [15:0] upper;
    logic [15:0] lower;
    logic above;
    logic below;

    modport ctl (output raw, gain, offset, ref_val, upper, lower, input scaled, above, below);
    modport scale (input raw, gain, offset, output scaled);
    modport window (input scaled, ref_val, upper, lower, output above, below);
endinterface

// ### core/band_scaler.sv
`timescale 1ns/10ps
module band_scaler (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // scaling path
    band_if.scale bus
);
    // everything kept in hundredths so the fractional gain needs no divider
    typedef struct packed {
        logic signed [31:0] scaled;
    } scaler_state_type;

    scaler_state_type st_ff;
    scaler_state_type nxt_st;
    logic signed [31:0] raw_w;
    logic signed [31:0] gain_w;
    logic signed [31:0] ofs_w;

    assign raw_w = 32'(bus.raw);
    assign gain_w = 32'(bus.gain);
    assign ofs_w = 32'(bus.offset);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.scaled = 32'(raw_w * gain_w) + 32'(ofs_w * band_pkg::SCALE_HUNDRED);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bus.scaled = st_ff.scaled;

    chk_scale_math: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.scaled == 32'($past(raw_w) * $past(gain_w)) + 32'($past(ofs_w) * band_pkg::SCALE_HUNDRED))
        else $error("scaled value is not raw times gain plus offset");
endmodule

// ### core/band_window.sv
`timescale 1ns/10ps
module band_window (
    // band compare
    band_if.window bus
);
    logic signed [31:0] hi_lim;
    logic signed [31:0] lo_lim;

    // margins held in whole units, reference in hundredths
    always_comb
    begin
        hi_lim = bus.ref_val + 32'(32'(bus.upper) * band_pkg::SCALE_HUNDRED);
        lo_lim = bus.ref_val - 32'(32'(bus.lower) * band_pkg::SCALE_HUNDRED);
        bus.above = bus.scaled > hi_lim;
        bus.below = bus.scaled < lo_lim;
    end
endmodule

// ### core/analog_band_monitor.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// Function
// - a rising edge of enable latches the scaled input as reference and starts band monitoring.
// - reference and live input are both scaled as raw times gain plus offset.
// - gain spans -10.00 to 10.00 in hundredths and offset spans -10000 to 10000.
// - the upper margin, 0 to 20000, sets how far above the reference the input may go.
// - the lower margin, 0 to 20000, sets how far below the reference the input may go.
// - the output is high while the monitor is armed, enable is high and the scaled input lies outside the band.
// - the output is low when the input is inside the band or enable is low.
// - each margin is a constant or the live value of another block chosen by number.
// - the decimal-places setting only affects display and never the comparison.
// - with retention on, status and reference survive a power loss.
// - a physical channel presents its input as 0 to 1000 before scaling.
// - on the legacy variant the gain is limited to 0.00 to 10.00.
module analog_band_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    // monitored signals
    input wire logic enable,
    input wire logic signed [15:0] analog_in,
    input wire logic [127:0] peer_values,
    input wire logic power_restore,
    // results
    output logic band_out,
    output logic irq
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic phys;
        logic retain;
        logic legacy;
        logic [1:0] dec;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic [15:0] up;
        logic [15:0] lo;
        logic [7:0] msrc;
        logic en_q;
        logic en_prev;
        logic armed;
        logic signed [31:0] ref_val;
        logic q;
        logic [2:0] istat;
        logic [2:0] imask;
        logic irq;
    } monitor_state_type;

    monitor_state_type st_ff;
    monitor_state_type nxt_st;
    band_if bif ();
    logic signed [15:0] peer_arr [band_pkg::PEER_NUM];
    logic req_w;
    logic edge_w;
    logic clear_w;
    logic [31:0] rd_w;
    logic [31:0] wm_w;
    logic [31:0] lane_w;
    logic wr_w;
    logic [2:0] set_w;
    logic [2:0] clr_w;

    for (genvar i = 0; i < band_pkg::PEER_NUM; i++)
    begin : g_peer
        assign peer_arr[i] = peer_values[i * band_pkg::VAL_W +: band_pkg::VAL_W];
    end

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // peer values are clamped too, a negative peer would otherwise read as a huge unsigned margin
    function automatic logic [15:0] margin_pick(input logic use_peer, input logic [2:0] sel, input logic [15:0] k);
        logic signed [31:0] pv;
        pv = 32'(peer_arr[sel]);
        margin_pick = use_peer ? 16'(clamp(pv, band_pkg::MARGIN_MIN, band_pkg::MARGIN_MAX)) : k;
    endfunction

    // datapath hookup
    assign bif.raw = st_ff.phys ? 16'(clamp(32'(analog_in), band_pkg::PHYS_MIN, band_pkg::PHYS_MAX))
                                : analog_in;
    assign bif.gain = 16'(clamp(32'(st_ff.gain), st_ff.legacy ? band_pkg::LEGACY_GAIN_MIN : band_pkg::GAIN_MIN,
                                band_pkg::GAIN_MAX));
    assign bif.offset = st_ff.offset;
    assign bif.ref_val = st_ff.ref_val;
    assign bif.upper = margin_pick(st_ff.msrc[band_pkg::MSRC_UP_PEER_BIT],
                                   st_ff.msrc[band_pkg::MSRC_UP_SEL_LSB +: band_pkg::PEER_SEL_W], st_ff.up);
    assign bif.lower = margin_pick(st_ff.msrc[band_pkg::MSRC_LO_PEER_BIT],
                                   st_ff.msrc[band_pkg::MSRC_LO_SEL_LSB +: band_pkg::PEER_SEL_W], st_ff.lo);

    band_scaler u_scaler (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus(bif.scale)
    );

    band_window u_window (
        .bus(bif.window)
    );

    // en_q lines up with the one-cycle scaler latency
    assign edge_w = st_ff.en_q & ~st_ff.en_prev;
    assign clear_w = power_restore & ~st_ff.retain;
    assign req_w = wb_cyc & wb_stb;
    assign wr_w = req_w & st_ff.ack & wb_we;
    assign lane_w = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    assign wm_w = (rd_w & ~lane_w) | (wb_dat_wr & lane_w);

    // register read view
    always_comb
    begin
        rd_w = '0;
        unique case (wb_adr)
            band_pkg::CTRL_OFS:
            begin
                rd_w[band_pkg::CTRL_PHYS_BIT] = st_ff.phys;
                rd_w[band_pkg::CTRL_RETAIN_BIT] = st_ff.retain;
                rd_w[band_pkg::CTRL_LEGACY_BIT] = st_ff.legacy;
                rd_w[band_pkg::CTRL_DEC_LSB +: band_pkg::DEC_W] = st_ff.dec;
            end
            band_pkg::GAIN_OFS: rd_w = 32'(st_ff.gain);
            band_pkg::OFFSET_OFS: rd_w = 32'(st_ff.offset);
            band_pkg::UPPER_OFS: rd_w = 32'(st_ff.up);
            band_pkg::LOWER_OFS: rd_w = 32'(st_ff.lo);
            band_pkg::MSRC_OFS: rd_w = 32'(st_ff.msrc);
            band_pkg::STATE_OFS:
            begin
                rd_w[band_pkg::STATE_OUT_BIT] = st_ff.q;
                rd_w[band_pkg::STATE_EN_BIT] = st_ff.en_q;
                rd_w[band_pkg::STATE_ARMED_BIT] = st_ff.armed;
            end
            band_pkg::REF_OFS: rd_w = st_ff.ref_val;
            band_pkg::LIVE_OFS: rd_w = bif.scaled;
            band_pkg::IRQ_STAT_OFS: rd_w = 32'(st_ff.istat);
            band_pkg::IRQ_MASK_OFS: rd_w = 32'(st_ff.imask);
            default: rd_w = '0;
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        clr_w = '0;
        set_w = '0;
        // ack one cycle after the request, dropped the cycle after
        nxt_st.ack = req_w & ~st_ff.ack;
        if (req_w & ~st_ff.ack)
            nxt_st.dat = rd_w;
        if (wr_w)
        begin
            unique case (wb_adr)
                band_pkg::CTRL_OFS:
                begin
                    nxt_st.phys = wm_w[band_pkg::CTRL_PHYS_BIT];
                    nxt_st.retain = wm_w[band_pkg::CTRL_RETAIN_BIT];
                    nxt_st.legacy = wm_w[band_pkg::CTRL_LEGACY_BIT];
                    nxt_st.dec = wm_w[band_pkg::CTRL_DEC_LSB +: band_pkg::DEC_W];
                end
                band_pkg::GAIN_OFS: nxt_st.gain = 16'(clamp(wm_w, band_pkg::GAIN_MIN, band_pkg::GAIN_MAX));
                band_pkg::OFFSET_OFS:
                    nxt_st.offset = 16'(clamp(wm_w, band_pkg::OFFSET_MIN, band_pkg::OFFSET_MAX));
                band_pkg::UPPER_OFS: nxt_st.up = 16'(clamp(wm_w, band_pkg::MARGIN_MIN, band_pkg::MARGIN_MAX));
                band_pkg::LOWER_OFS: nxt_st.lo = 16'(clamp(wm_w, band_pkg::MARGIN_MIN, band_pkg::MARGIN_MAX));
                band_pkg::MSRC_OFS: nxt_st.msrc = wm_w[7:0];
                band_pkg::IRQ_STAT_OFS: clr_w = wm_w[2:0];
                band_pkg::IRQ_MASK_OFS: nxt_st.imask = wm_w[2:0];
                default: nxt_st.imask = st_ff.imask;
            endcase
        end

        // monitoring core
        nxt_st.en_q = enable;
        nxt_st.en_prev = st_ff.en_q;
        if (clear_w)
        begin
            nxt_st.armed = 1'b0;
            nxt_st.ref_val = '0;
            nxt_st.q = 1'b0;
        end
        else if (edge_w)
        begin
            nxt_st.ref_val = bif.scaled;
            nxt_st.armed = 1'b1;
            nxt_st.q = 1'b0;
        end
        else if (!st_ff.en_q)
        begin
            nxt_st.armed = 1'b0;
            nxt_st.q = 1'b0;
        end
        else
            nxt_st.q = st_ff.armed & (bif.above | bif.below);

        // events; a set in the clearing cycle wins
        set_w[band_pkg::IRQ_EXIT_BIT] = nxt_st.q & ~st_ff.q;
        set_w[band_pkg::IRQ_RETURN_BIT] = ~nxt_st.q & st_ff.q;
        set_w[band_pkg::IRQ_CAPTURE_BIT] = edge_w & ~clear_w;
        nxt_st.istat = (st_ff.istat & ~clr_w) | set_w;
        nxt_st.irq = |(st_ff.istat & st_ff.imask);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
            st_ff.gain <= band_pkg::GAIN_RST;
            st_ff.offset <= band_pkg::OFFSET_RST;
            st_ff.up <= band_pkg::MARGIN_RST;
            st_ff.lo <= band_pkg::MARGIN_RST;
            st_ff.msrc <= band_pkg::MSRC_RST;
            st_ff.imask <= band_pkg::IRQ_MASK_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign wb_ack = st_ff.ack;
    assign wb_dat_rd = st_ff.dat;
    assign band_out = st_ff.q;
    assign irq = st_ff.irq;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_ref_capture: assert property ((edge_w && !clear_w) |=> st_ff.ref_val == $past(bif.scaled))
        else $error("reference not latched on enable rise");
    chk_band_exit: assert property ((st_ff.en_q && st_ff.armed && !edge_w && !clear_w
        && (bif.above || bif.below)) |=> band_out)
        else $error("output low while input outside band");
    chk_band_inside: assert property ((!bif.above && !bif.below) |=> !band_out)
        else $error("output high while input inside band");
    chk_enable_low: assert property (!st_ff.en_q |=> !band_out && !st_ff.armed)
        else $error("output or armed state kept while enable low");
    chk_gain_range: assert property (bif.gain >= -16'sd1000 && bif.gain <= 16'sd1000)
        else $error("gain outside ten either way");
    chk_legacy_gain: assert property (st_ff.legacy |-> bif.gain >= 16'sd0)
        else $error("negative gain on legacy variant");
    chk_upper_range: assert property (bif.upper <= 16'd20000)
        else $error("upper margin above limit");
    chk_lower_range: assert property (bif.lower <= 16'd20000)
        else $error("lower margin above limit");
    chk_phys_clamp: assert property (st_ff.phys |-> bif.raw >= 16'sd0 && bif.raw <= 16'sd1000)
        else $error("physical channel outside 0 to 1000");
    chk_retain_hold: assert property ((power_restore && st_ff.retain && !edge_w)
        |=> st_ff.ref_val == $past(st_ff.ref_val) && st_ff.armed == $past(st_ff.armed && st_ff.en_q))
        else $error("retained status lost on power restore");
    chk_edge_sample: assert property ((enable && !st_ff.en_q) ##1 !st_ff.en_prev |-> edge_w)
        else $error("enable rise not seen from previous sample");
    chk_irq_level: assert property (irq == $past(|(st_ff.istat & st_ff.imask)))
        else $error("interrupt does not follow masked status");
    chk_irq_masked: assert property ((st_ff.imask == 3'h0) |=> !irq)
        else $error("interrupt raised with every source masked");
    chk_ack_pulse: assert property (st_ff.ack |=> !st_ff.ack)
        else $error("acknowledge held for more than one cycle");
    chk_ack_answer: assert property ((req_w && !st_ff.ack) |=> st_ff.ack)
        else $error("request not acknowledged in the next cycle");
    // a status bit set in the same cycle as its clear must survive
    chk_set_wins: assert property ((|set_w) |=> ((st_ff.istat & $past(set_w)) == $past(set_w)))
        else $error("status event lost");
    chk_clear_status: assert property (clear_w |=> !st_ff.armed && !band_out && st_ff.ref_val == 32'sd0)
        else $error("status kept on power restore without retention");
    chk_capture_arms: assert property ((edge_w && !clear_w) |=> st_ff.armed && !band_out
        && st_ff.istat[band_pkg::IRQ_CAPTURE_BIT])
        else $error("capture did not arm the monitor");
    chk_exit_flag: assert property ($rose(band_out) |-> st_ff.istat[band_pkg::IRQ_EXIT_BIT])
        else $error("band exit not flagged");
    chk_offset_range: assert property (st_ff.offset >= -16'sd10000 && st_ff.offset <= 16'sd10000)
        else $error("offset outside its range");
endmodule

// ### sim/analog_source.sv
`timescale 1ns/10ps
// stands in for the analog channel and the peer blocks feeding the monitor
module analog_source (
    // clock
    input wire logic ref_clk,
    // load request from the bench; index 8 is the channel, 0 to 7 the peers
    input wire logic load,
    input wire logic [3:0] load_sel,
    input wire logic signed [15:0] load_val,
    // values seen by the monitor
    output logic signed [15:0] analog_in,
    output logic [127:0] peer_values
);
    logic signed [15:0] chan_ff = 16'sh0000;
    logic [127:0] peers_ff = 128'h0;

    // values only move just after an edge, like a converter that updates per scan
    always @(posedge ref_clk)
    begin
        if (load && load_sel == 4'h8)
            chan_ff <= load_val;
        else if (load)
            peers_ff[load_sel[2:0]*16 +: 16] <= load_val;
    end

    assign analog_in = chan_ff;
    assign peer_values = peers_ff;
endmodule

// ### sim/analog_band_monitor_bench.sv
`timescale 1ns/10ps
module analog_band_monitor_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_wr = 32'h0;
    logic [31:0] wb_dat_rd;
    logic wb_ack;
    logic enable = 1'b0;
    logic signed [15:0] analog_in;
    logic [127:0] peer_values;
    logic power_restore = 1'b0;
    logic band_out;
    logic irq;
    logic load = 1'b0;
    logic [3:0] load_sel = 4'h0;
    logic signed [15:0] load_val = 16'sh0000;
    logic [31:0] rnd = 32'd11248;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic signed [31:0] gain, offs, up, lo, refv, live, a0;
    logic [31:0] rd;
    logic [7:0] adrs [6] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h10};
    logic [31:0] wvals [6] = '{32'd2000, -32'sd5000, 32'd20000, -32'sd20000, 32'd25000, 32'd20000};
    logic [31:0] evals [6] = '{32'd1000, -32'sd1000, 32'd10000, -32'sd10000, 32'd20000, 32'd20000};

    analog_band_monitor analog_band_monitor_i (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr),
        .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .enable(enable), .analog_in(analog_in),
        .peer_values(peer_values), .power_restore(power_restore), .band_out(band_out), .irq(irq));
    analog_source analog_source_i (.ref_clk(ref_clk), .load(load), .load_sel(load_sel), .load_val(load_val),
        .analog_in(analog_in), .peer_values(peer_values));

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // everything is kept in hundredths, so the offset is scaled up by 100
    function automatic logic signed [31:0] scale(input logic signed [31:0] raw, g, o);
        return raw * g + o * 32'sd100;
    endfunction

    function automatic logic outside(input logic signed [31:0] v);
        return (v > refv + up * 32'sd100) || (v < refv - lo * 32'sd100);
    endfunction

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat_wr <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack !== 1'b1);
        rd = wb_dat_rd;
        check("wb_ack_wait", 32'd2, 32'(n));
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, 4'hf, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 4'hf, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic set_in(input logic [3:0] sel, input logic signed [31:0] v);
        @(posedge ref_clk);
        load <= 1'b1;
        load_sel <= sel;
        load_val <= v[15:0];
        @(posedge ref_clk);
        load <= 1'b0;
    endtask

    task automatic settle;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic drive(input logic en, input logic pr);
        @(posedge ref_clk);
        enable <= en;
        power_restore <= pr;
    endtask

    task automatic cfg(input int g, input int o, input int u, input int l);
        gain = g;
        offs = o;
        up = u;
        lo = l;
        wr(band_pkg::GAIN_OFS, 32'(g));
        wr(band_pkg::OFFSET_OFS, 32'(o));
        wr(band_pkg::UPPER_OFS, 32'(u));
        wr(band_pkg::LOWER_OFS, 32'(l));
    endtask

    task automatic capture(input logic signed [31:0] raw);
        set_in(4'h8, raw);
        drive(1'b0, 1'b0);
        settle();
        check("band_out_off", 32'h0, {31'h0, band_out});
        drive(1'b1, 1'b0);
        settle();
        refv = scale(raw, gain, offs);
        rdchk("ref", band_pkg::REF_OFS, refv);
    endtask

    task automatic probe(input logic signed [31:0] raw);
        set_in(4'h8, raw);
        settle();
        live = scale(raw, gain, offs);
        rdchk("live", band_pkg::LIVE_OFS, live);
        check("band_out", {31'h0, outside(live)}, {31'h0, band_out});
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        check("band_out_rst", 32'h0, {31'h0, band_out});
        check("irq_rst", 32'h0, {31'h0, irq});
        rdchk("gain_rst", band_pkg::GAIN_OFS, 32'h0000_0064);
        for (int i = 0; i <= 8'h28; i += 4)
            if (i != 4 && i != 8'h20)
                rdchk("reg_rst", 8'(i), 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rdchk("unmapped", 8'h3c, 32'h0);
        wr(band_pkg::REF_OFS, 32'h0000_1234);
        rdchk("ref_ro", band_pkg::REF_OFS, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(adrs[i], wvals[i]);
            rdchk("clamp", adrs[i], evals[i]);
        end
        wr(band_pkg::UPPER_OFS, 32'h0000_0500);
        wb(band_pkg::UPPER_OFS, 1'b1, 4'h1, 32'h0000_1234);
        rdchk("lane_merge", band_pkg::UPPER_OFS, 32'h0000_0534);
        // hand-picked band with both limits hit exactly
        cfg(100, 0, 5, 3);
        wr(band_pkg::IRQ_STAT_OFS, 32'h7);
        wr(band_pkg::IRQ_MASK_OFS, 32'h1);
        capture(200);
        rdchk("stat_capture", band_pkg::IRQ_STAT_OFS, 32'h4);
        probe(205);
        probe(206);
        check("irq_on", 32'h1, {31'h0, irq});
        probe(197);
        probe(196);
        probe(200);
        rdchk("stat_all", band_pkg::IRQ_STAT_OFS, 32'h7);
        wr(band_pkg::IRQ_STAT_OFS, 32'h1);
        settle();
        check("irq_clear", 32'h0, {31'h0, irq});
        rdchk("stat_left", band_pkg::IRQ_STAT_OFS, 32'h6);
        drive(1'b0, 1'b0);
        set_in(4'h8, 400);
        settle();
        check("band_out_dis", 32'h0, {31'h0, band_out});
        // display precision must not move the band
        wr(band_pkg::CTRL_OFS, 32'h30);
        capture(200);
        probe(206);
        probe(205);
        rdchk("ctrl_dec", band_pkg::CTRL_OFS, 32'h30);
        set_in(4'h5, 20);
        wr(band_pkg::MSRC_OFS, 32'h0d);
        up = 20;
        probe(220);
        probe(221);
        set_in(4'h6, 10);
        wr(band_pkg::MSRC_OFS, 32'he0);
        up = 5;
        lo = 10;
        probe(190);
        probe(189);
        wr(band_pkg::MSRC_OFS, 32'h0);
        lo = 3;
        wr(band_pkg::CTRL_OFS, 32'h1);
        set_in(4'h8, 1500);
        settle();
        rdchk("phys_hi", band_pkg::LIVE_OFS, scale(1000, gain, offs));
        set_in(4'h8, -40);
        settle();
        rdchk("phys_lo", band_pkg::LIVE_OFS, scale(0, gain, offs));
        wr(band_pkg::CTRL_OFS, 32'h4);
        cfg(-200, 7, 5, 3);
        set_in(4'h8, 50);
        settle();
        rdchk("legacy", band_pkg::LIVE_OFS, scale(50, 0, offs));
        rdchk("legacy_gain", band_pkg::GAIN_OFS, -32'sd200);
        // retention keeps the reference over a power dip, otherwise it is lost
        wr(band_pkg::CTRL_OFS, 32'h2);
        cfg(100, 0, 5, 3);
        capture(300);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        settle();
        rdchk("ref_kept", band_pkg::REF_OFS, refv);
        wr(band_pkg::CTRL_OFS, 32'h0);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        settle();
        rdchk("ref_lost", band_pkg::REF_OFS, 32'h0);
        check("band_out_lost", 32'h0, {31'h0, band_out});
        // small margins so random probes land on both sides of the band
        for (int k = 0; k < 10; k++)
        begin
            rnd = xs(rnd);
            gain = int'(rnd % 32'd2001) - 1000;
            rnd = xs(rnd);
            offs = int'(rnd % 32'd20001) - 10000;
            rnd = xs(rnd);
            cfg(gain, offs, int'(rnd % 32'd301), int'(rnd[31:16] % 16'd301));
            rnd = xs(rnd);
            a0 = int'(rnd % 32'd2001) - 1000;
            capture(a0);
            for (int j = 0; j < 6; j++)
            begin
                rnd = xs(rnd);
                probe(a0 + int'(rnd % 32'd41) - 20);
            end
        end
        final_report();
    end
endmodule
